/* src/sdrc_pkg.sv */
// sdrc_pkg: register map, timing constants and types of the sdram refresh/command controller
// ****************************************************************
// Behaviour
// - periodic auto refresh at selected interval
// - enable bit gates periodic refresh
// - cpu stalled during auto refresh
// - periodic refresh only in normal or light idle
// - command codes: none, init, mrs, sr in/out
// - init: precharge all, 8 refreshes, mode set
// - field self-clears, except during self refresh
// - sdram pins deselected while controller disabled, once the sequencer is idle
// - row and column address multiplexing
// - full page burst: mrs before, precharge after
// - fixed access length, no wait states used
// - no auto refresh while in self refresh
// - exit by code 110 or halt release
// - one refresh at once after exit
// - auto-exit enable bit, reset one
// - reset returns registers, refresh stopped
// - init stalls cpu, field clears when done
// ****************************************************************
`default_nettype none
package sdrc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] OFF_RFCTL = 12'h252; // refresh control
  localparam logic [11:0] OFF_CMD = 12'h253; // command field
  localparam logic [4:0] RST_RFCTL = 5'h10; // auto exit on, refresh off
  localparam logic [2:0] RST_CMD = 3'h0;
  // command codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_INIT = 3'h1;
  localparam logic [2:0] CODE_MRS = 3'h4;
  localparam logic [2:0] CODE_SRIN = 3'h5;
  localparam logic [2:0] CODE_SROUT = 3'h6;
  // refresh interval in system clock states, indexed by the select field
  localparam logic [8:0] REF_INTERVAL [8] = '{9'h02F, 9'h04E, 9'h061, 9'h07C,
                                              9'h09C, 9'h0C3, 9'h0F9, 9'h138};
  // burst length select that means full page
  localparam logic [1:0] BL_FULL_PAGE = 2'h1;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int T_RP_NS = 20; // precharge
  localparam int T_RC_NS = 66; // refresh cycle
  localparam int T_RCD_NS = 20; // activate to column
  localparam int T_XSR_NS = 75; // self refresh exit
  localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XSR_CYC = (T_XSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_MRD_CYC = 2;
  localparam int CAS_LAT = 2;
  localparam int ACC_SINGLE_CYC = CAS_LAT + 1;
  localparam int ACC_BURST_CYC = 8;
  localparam logic [3:0] W_RP = 4'(T_RP_CYC - 1);
  localparam logic [3:0] W_RC = 4'(T_RC_CYC - 1);
  localparam logic [3:0] W_RCD = 4'(T_RCD_CYC - 1);
  localparam logic [3:0] W_XSR = 4'(T_XSR_CYC - 1);
  localparam logic [3:0] W_MRD = 4'(T_MRD_CYC - 1);
  localparam logic [3:0] W_SINGLE = 4'(ACC_SINGLE_CYC - 1);
  localparam logic [3:0] W_BURST = 4'(ACC_BURST_CYC - 1);
  localparam logic [2:0] INIT_AREF_LAST = 3'h7; // eight refreshes
  localparam logic [3:0] INIT_AREF_COUNT = 4'h8;
  // mode register word: cas latency 2, sequential
  localparam logic [15:0] MRS_BASE = 16'h0020;
  localparam logic [2:0] MRS_BL_FULL = 3'h7;
  localparam logic [2:0] MRS_BL_ONE = 3'h0;
  localparam logic [15:0] PRE_ALL_ADDR = 16'h0400;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdrc_cmd_t;
  localparam sdrc_cmd_t CMD_DESEL = 4'hF;
  localparam sdrc_cmd_t CMD_NOP = 4'h7;
  localparam sdrc_cmd_t CMD_ACT = 4'h3;
  localparam sdrc_cmd_t CMD_RD = 4'h5;
  localparam sdrc_cmd_t CMD_WR = 4'h4;
  localparam sdrc_cmd_t CMD_PRE = 4'h2;
  localparam sdrc_cmd_t CMD_AREF = 4'h1;
  localparam sdrc_cmd_t CMD_MRS = 4'h0;
  typedef struct packed {
    logic aex; // auto exit on halt release
    logic [2:0] interval;
    logic ar_en; // periodic refresh enable
  } sdrc_rfctl_t;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_PRE = 8'h02,
    ST_AREF = 8'h04,
    ST_MRS = 8'h08,
    ST_ACT = 8'h10,
    ST_ACC = 8'h20,
    ST_SREF = 8'h40,
    ST_SXIT = 8'h80
  } sdrc_state_t;
endpackage
`default_nettype wire

/* src/sdrc_ctrl.sv */
// sdrc_ctrl: sdram refresh, command sequencing and cpu access controller
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
module sdrc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // configuration from the access-control registers
  input wire logic controller_enable,
  input wire logic [1:0] burst_length_sel,
  input wire logic [1:0] addr_type,
  input wire logic bus_is_32,
  // cpu power state
  input wire logic deep_idle_mode,
  input wire logic stop_mode,
  input wire logic halt_release,
  // cpu access to the chip-select-3 area
  input wire logic cpu_req,
  input wire logic [26:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_byte_en,
  output logic cpu_ack,
  output logic cpu_stall,
  // sdram pins
  output var sdrc_pkg::sdrc_cmd_t mem_cmd,
  output logic [15:0] mem_addr,
  output logic low_byte_mask,
  output logic high_byte_mask,
  output logic mem_clock_out,
  output logic mem_clock_enable
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  sdrc_pkg::sdrc_state_t state_r, state_nxt; // sequencer state
  logic [3:0] wait_r, wait_nxt; // cycles left in current command
  logic init_r, init_nxt; // inside the initialize sequence
  logic burst_r, burst_nxt; // current access is full page
  logic [2:0] aref_left_r, aref_left_nxt; // init refreshes still to go
  logic [2:0] cmd_r; // command field
  logic cmd_clr; // sequencer finished a command
  sdrc_pkg::sdrc_rfctl_t ctrl_r; // refresh control register
  logic [8:0] timer_r; // refresh interval down counter
  logic ref_pend_r; // refresh owed to the sdram
  logic ref_take; // sequencer starts the owed refresh
  logic [26:0] acc_addr_r; // latched cpu address
  logic acc_wr_r;
  logic [1:0] acc_be_r;
  logic acc_load;
  logic ack_r;
  sdrc_pkg::sdrc_cmd_t cmd_nxt;
  logic [15:0] addr_nxt;
  logic cke_nxt;
  logic [1:0] mask_nxt;
  logic ack_nxt;
  logic [3:0] init_aref_seen_r; // helper count for checking
  // ****************************************************************
  // decode
  // ****************************************************************
  wire wait_done = (wait_r == 4'h0);
  wire wr_rfc = reg_wr && (reg_addr == sdrc_pkg::OFF_RFCTL);
  wire wr_cmd = reg_wr && (reg_addr == sdrc_pkg::OFF_CMD);
  wire rd_rfc = reg_rd && (reg_addr == sdrc_pkg::OFF_RFCTL);
  wire rd_cmd = reg_rd && (reg_addr == sdrc_pkg::OFF_CMD);
  wire in_sref = (state_r == sdrc_pkg::ST_SREF);
  wire sw_exit = wr_cmd && (reg_wdata[2:0] == sdrc_pkg::CODE_SROUT);
  // halt release only ends self refresh when the auto-exit bit allows it
  wire auto_exit = halt_release && ctrl_r.aex;
  wire sref_exit = in_sref && (sw_exit || auto_exit);
  // periodic refresh needs the enable bit, a running cpu and no self refresh
  wire ref_allowed = ctrl_r.ar_en && controller_enable && !deep_idle_mode
                     && !stop_mode && !in_sref;
  wire timer_zero = (timer_r == 9'h000);
  wire [8:0] ref_reload = sdrc_pkg::REF_INTERVAL[ctrl_r.interval] - 9'h001;
  wire full_page = (burst_length_sel == sdrc_pkg::BL_FULL_PAGE);
  // address mux source: the live cpu address while the access is taken
  wire [26:0] acc_src = (state_r == sdrc_pkg::ST_IDLE) ? cpu_addr : acc_addr_r;
  wire [4:0] row_shift = 5'h09 + {3'h0, addr_type};
  wire [26:0] row_wide = acc_src >> row_shift;
  wire [26:0] col_wide = bus_is_32 ? (acc_src >> 2) : (acc_src >> 1);
  // pin A10 carries auto precharge; a full page burst precharges explicitly
  wire [15:0] col_addr = {5'h00, !burst_r, col_wide[9:0]};
  wire [15:0] mrs_addr = sdrc_pkg::MRS_BASE
                         | {13'h0000, full_page ? sdrc_pkg::MRS_BL_FULL : sdrc_pkg::MRS_BL_ONE};
  // refresh and initialization hold the cpu off the bus
  assign cpu_stall = init_r || (state_r == sdrc_pkg::ST_AREF);
  assign cpu_ack = ack_r;
  // ****************************************************************
  // sequencer
  // ****************************************************************
  // one command per state entry or per init refresh, then wait out its fixed length
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_done ? 4'h0 : wait_r - 4'h1;
    init_nxt = init_r;
    burst_nxt = burst_r;
    aref_left_nxt = aref_left_r;
    cmd_nxt = sdrc_pkg::CMD_DESEL;
    addr_nxt = mem_addr;
    cke_nxt = mem_clock_enable;
    mask_nxt = {high_byte_mask, low_byte_mask};
    ack_nxt = 1'b0;
    cmd_clr = 1'b0;
    ref_take = 1'b0;
    acc_load = 1'b0;
    case (state_r)
      sdrc_pkg::ST_IDLE: begin
        // pins stay deselected while the controller is disabled
        if (controller_enable && !ack_r) begin
          if (cmd_r == sdrc_pkg::CODE_INIT) begin
            state_nxt = sdrc_pkg::ST_PRE;
            wait_nxt = sdrc_pkg::W_RP;
            cmd_nxt = sdrc_pkg::CMD_PRE;
            addr_nxt = sdrc_pkg::PRE_ALL_ADDR;
            init_nxt = 1'b1;
          end else if (cmd_r == sdrc_pkg::CODE_MRS) begin
            state_nxt = sdrc_pkg::ST_MRS;
            wait_nxt = sdrc_pkg::W_MRD;
            cmd_nxt = sdrc_pkg::CMD_MRS;
            addr_nxt = mrs_addr;
          end else if (cmd_r == sdrc_pkg::CODE_SRIN) begin
            state_nxt = sdrc_pkg::ST_SREF;
            cmd_nxt = sdrc_pkg::CMD_AREF;
            cke_nxt = 1'b0;
          end else if (cmd_r != sdrc_pkg::CODE_NONE) begin
            // reserved or stray exit code: nothing to do, drop it
            cmd_clr = 1'b1;
          end else if (ref_pend_r) begin
            state_nxt = sdrc_pkg::ST_AREF;
            wait_nxt = sdrc_pkg::W_RC;
            cmd_nxt = sdrc_pkg::CMD_AREF;
            ref_take = 1'b1;
          end else if (cpu_req) begin
            acc_load = 1'b1;
            burst_nxt = full_page;
            if (full_page) begin
              state_nxt = sdrc_pkg::ST_MRS;
              wait_nxt = sdrc_pkg::W_MRD;
              cmd_nxt = sdrc_pkg::CMD_MRS;
              addr_nxt = mrs_addr;
            end else begin
              state_nxt = sdrc_pkg::ST_ACT;
              wait_nxt = sdrc_pkg::W_RCD;
              cmd_nxt = sdrc_pkg::CMD_ACT;
              addr_nxt = row_wide[15:0];
            end
          end
        end
      end
      sdrc_pkg::ST_PRE: begin
        cmd_nxt = sdrc_pkg::CMD_NOP;
        if (wait_done) begin
          if (init_r) begin
            state_nxt = sdrc_pkg::ST_AREF;
            wait_nxt = sdrc_pkg::W_RC;
            cmd_nxt = sdrc_pkg::CMD_AREF;
            aref_left_nxt = sdrc_pkg::INIT_AREF_LAST;
          end else begin
            // precharge closing a full page burst ends the access
            state_nxt = sdrc_pkg::ST_IDLE;
            burst_nxt = 1'b0;
            ack_nxt = 1'b1;
            cmd_nxt = sdrc_pkg::CMD_DESEL;
          end
        end
      end
      sdrc_pkg::ST_AREF: begin
        cmd_nxt = sdrc_pkg::CMD_NOP;
        if (wait_done) begin
          if (init_r && (aref_left_r != 3'h0)) begin
            wait_nxt = sdrc_pkg::W_RC;
            cmd_nxt = sdrc_pkg::CMD_AREF;
            aref_left_nxt = aref_left_r - 3'h1;
          end else if (init_r) begin
            state_nxt = sdrc_pkg::ST_MRS;
            wait_nxt = sdrc_pkg::W_MRD;
            cmd_nxt = sdrc_pkg::CMD_MRS;
            addr_nxt = mrs_addr;
          end else begin
            state_nxt = sdrc_pkg::ST_IDLE;
            cmd_nxt = sdrc_pkg::CMD_DESEL;
          end
        end
      end
      sdrc_pkg::ST_MRS: begin
        cmd_nxt = sdrc_pkg::CMD_NOP;
        if (wait_done) begin
          if (burst_r) begin
            state_nxt = sdrc_pkg::ST_ACT;
            wait_nxt = sdrc_pkg::W_RCD;
            cmd_nxt = sdrc_pkg::CMD_ACT;
            addr_nxt = row_wide[15:0];
          end else begin
            // end of mode set or of the whole initialize sequence
            state_nxt = sdrc_pkg::ST_IDLE;
            cmd_nxt = sdrc_pkg::CMD_DESEL;
            init_nxt = 1'b0;
            cmd_clr = 1'b1;
          end
        end
      end
      sdrc_pkg::ST_ACT: begin
        cmd_nxt = sdrc_pkg::CMD_NOP;
        if (wait_done) begin
          // access length is fixed here, no bus wait states enter it
          state_nxt = sdrc_pkg::ST_ACC;
          wait_nxt = burst_r ? sdrc_pkg::W_BURST : sdrc_pkg::W_SINGLE;
          cmd_nxt = acc_wr_r ? sdrc_pkg::CMD_WR : sdrc_pkg::CMD_RD;
          addr_nxt = col_addr;
          mask_nxt = acc_wr_r ? ~acc_be_r : 2'h0;
        end
      end
      sdrc_pkg::ST_ACC: begin
        cmd_nxt = sdrc_pkg::CMD_NOP;
        if (wait_done) begin
          mask_nxt = 2'h3;
          if (burst_r) begin
            state_nxt = sdrc_pkg::ST_PRE;
            wait_nxt = sdrc_pkg::W_RP;
            cmd_nxt = sdrc_pkg::CMD_PRE;
            addr_nxt = sdrc_pkg::PRE_ALL_ADDR;
          end else begin
            state_nxt = sdrc_pkg::ST_IDLE;
            cmd_nxt = sdrc_pkg::CMD_DESEL;
            ack_nxt = 1'b1;
          end
        end
      end
      sdrc_pkg::ST_SREF: begin
        // the sdram refreshes itself: issue nothing until an exit
        if (sref_exit) begin
          state_nxt = sdrc_pkg::ST_SXIT;
          wait_nxt = sdrc_pkg::W_XSR;
          cmd_nxt = sdrc_pkg::CMD_NOP;
          cke_nxt = 1'b1;
          cmd_clr = 1'b1;
        end
      end
      sdrc_pkg::ST_SXIT: begin
        cmd_nxt = sdrc_pkg::CMD_NOP;
        if (wait_done) begin
          state_nxt = sdrc_pkg::ST_IDLE;
          cmd_nxt = sdrc_pkg::CMD_DESEL;
        end
      end
      default: begin
        state_nxt = sdrc_pkg::ST_IDLE;
      end
    endcase
  end
  // state and sdram pin flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sdrc_pkg::ST_IDLE;
      wait_r <= 4'h0;
      init_r <= 1'b0;
      burst_r <= 1'b0;
      aref_left_r <= 3'h0;
      mem_cmd <= sdrc_pkg::CMD_DESEL;
      mem_addr <= 16'h0000;
      mem_clock_enable <= 1'b1;
      {high_byte_mask, low_byte_mask} <= 2'h3;
      ack_r <= 1'b0;
      mem_clock_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      init_r <= init_nxt;
      burst_r <= burst_nxt;
      aref_left_r <= aref_left_nxt;
      mem_cmd <= cmd_nxt;
      mem_addr <= addr_nxt;
      mem_clock_enable <= cke_nxt;
      {high_byte_mask, low_byte_mask} <= mask_nxt;
      ack_r <= ack_nxt;
      mem_clock_out <= controller_enable;
    end
  end
  // latch the cpu request when it is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_addr_r <= 27'h0000000;
      acc_wr_r <= 1'b0;
      acc_be_r <= 2'h0;
    end else if (acc_load) begin
      acc_addr_r <= cpu_addr;
      acc_wr_r <= cpu_wr;
      acc_be_r <= cpu_byte_en;
    end
  end
  // ****************************************************************
  // refresh timer
  // ****************************************************************
  // reloads while refresh is not allowed, so it restarts a full interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= 9'h000;
    end else if (!ref_allowed || timer_zero) begin
      timer_r <= ref_reload;
    end else begin
      timer_r <= timer_r - 9'h001;
    end
  end
  // owed refresh: a new request wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_pend_r <= 1'b0;
    end else if (sref_exit || (ref_allowed && timer_zero)) begin
      ref_pend_r <= 1'b1;
    end else if (ref_take || deep_idle_mode || stop_mode || !controller_enable || in_sref) begin
      ref_pend_r <= 1'b0;
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  // software write wins over the self-clear; no command field write is stored in the cycle that exits self refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= sdrc_pkg::RST_RFCTL;
      cmd_r <= sdrc_pkg::RST_CMD;
    end else begin
      if (wr_rfc) begin
        ctrl_r <= reg_wdata[4:0];
      end
      if (wr_cmd && !sref_exit) begin
        cmd_r <= reg_wdata[2:0];
      end else if (cmd_clr) begin
        cmd_r <= sdrc_pkg::CODE_NONE;
      end
    end
  end
  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_rfc ? {3'h0, ctrl_r} : (rd_cmd ? {5'h00, cmd_r} : 8'h00);
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  // counts refresh commands seen during initialization
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_aref_seen_r <= 4'h0;
    end else if (!init_r) begin
      init_aref_seen_r <= 4'h0;
    end else if (mem_cmd == sdrc_pkg::CMD_AREF) begin
      init_aref_seen_r <= init_aref_seen_r + 4'h1;
    end
  end
  a_refresh_tick: assert property (@(posedge clk) disable iff (!rst_n)
    (ref_allowed && timer_zero) |=> ref_pend_r)
    else $error("interval expiry did not raise a refresh");
  a_refresh_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_r.ar_en && !sref_exit && !ref_pend_r) |=> !ref_pend_r)
    else $error("refresh raised while disabled");
  a_refresh_stall: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_cmd == sdrc_pkg::CMD_AREF && mem_clock_enable) |-> cpu_stall && !cpu_ack)
    else $error("cpu not stalled during refresh");
  a_deep_idle_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ((deep_idle_mode || stop_mode) && !sref_exit) |=> !ref_pend_r)
    else $error("refresh owed in deep idle or stop");
  a_init_order: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == sdrc_pkg::ST_PRE && init_r && wait_done)
    |=> (state_r == sdrc_pkg::ST_AREF) && (mem_cmd == sdrc_pkg::CMD_AREF))
    else $error("init precharge not followed by refresh");
  a_init_count: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_cmd == sdrc_pkg::CMD_MRS && init_r) |-> init_aref_seen_r == sdrc_pkg::INIT_AREF_COUNT)
    else $error("init mode set without eight refreshes");
  a_cmd_selfclear: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == sdrc_pkg::ST_MRS && wait_done && !burst_r && !wr_cmd)
    |=> (cmd_r == sdrc_pkg::CODE_NONE) && !cpu_stall)
    else $error("command field not cleared after mode set");
  a_sref_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (in_sref && !wr_cmd && !sref_exit) |=> cmd_r == sdrc_pkg::CODE_SRIN)
    else $error("self refresh code not held");
  a_sref_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (in_sref && !sref_exit) |=> in_sref && (mem_cmd == sdrc_pkg::CMD_DESEL))
    else $error("command issued during self refresh");
  a_exit_refresh: assert property (@(posedge clk) disable iff (!rst_n)
    (sref_exit && controller_enable) |=> ref_pend_r ##[1:16] (mem_cmd == sdrc_pkg::CMD_AREF))
    else $error("no refresh right after self refresh exit");
  a_auto_exit_off: assert property (@(posedge clk) disable iff (!rst_n)
    (in_sref && !ctrl_r.aex && !sw_exit) |=> in_sref)
    else $error("self refresh left with auto exit disabled");
  a_cke_sref: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(in_sref) |-> !mem_clock_enable ##1 (!mem_clock_enable || !in_sref))
    else $error("clock enable high in self refresh");
  a_pins_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    (!controller_enable && state_r == sdrc_pkg::ST_IDLE) [*2] |-> mem_cmd == sdrc_pkg::CMD_DESEL)
    else $error("sdram pins active while controller disabled");
endmodule
`default_nettype wire

/* tb/sdrc_sdram_model.sv */
// sdrc_sdram_model: behavioural sdram chip that tallies the commands it receives
`default_nettype none
module sdrc_sdram_model (
  // pins from the controller
  input wire logic clk,
  input wire sdrc_pkg::sdrc_cmd_t cmd,
  input wire logic cke,
  // tallies for the bench
  output int n_aref,
  output int n_pre,
  output int n_mrs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // command decode
  // ****
  // an aref with cke low is self refresh entry, so it is kept out of the tally
  always @(posedge clk) begin
    if (cmd == sdrc_pkg::CMD_AREF && cke) n_aref <= n_aref + 1;
    if (cmd == sdrc_pkg::CMD_PRE) n_pre <= n_pre + 1;
    if (cmd == sdrc_pkg::CMD_MRS) n_mrs <= n_mrs + 1;
  end
endmodule
`default_nettype wire

/* tb/sdrc_ctrl_tb_top.sv */
// sdrc_ctrl_tb_top: self-checking bench of the sdram refresh and command controller
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module sdrc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // stimulus and observation
  // ****
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sa = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic en = 1'b1, b32 = 1'b0, deep = 1'b0, stp = 1'b0, hr = 1'b0;
  logic req = 1'b0, cwr = 1'b0, ack, stall, lm, hm, mco, cke;
  logic [1:0] bl = 2'h0, aty = 2'h0, be = 2'h0;
  logic [26:0] ca = 27'h0000000;
  logic [15:0] ma;
  sdrc_pkg::sdrc_cmd_t mc;
  int err_count = 0, samples_checked = 0, n_aref, n_pre, n_mrs, t;
  int ivl[8] = '{47, 78, 97, 124, 156, 195, 249, 312};
  always #4 clk = ~clk;
  sdrc_ctrl i_sdrc_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .controller_enable(en),
    .burst_length_sel(bl), .addr_type(aty), .bus_is_32(b32), .deep_idle_mode(deep),
    .stop_mode(stp), .halt_release(hr), .cpu_req(req), .cpu_addr(ca), .cpu_wr(cwr),
    .cpu_byte_en(be), .cpu_ack(ack), .cpu_stall(stall), .mem_cmd(mc), .mem_addr(ma),
    .low_byte_mask(lm), .high_byte_mask(hm), .mem_clock_out(mco), .mem_clock_enable(cke));
  sdrc_sdram_model i_sdrc_sdram_model (.clk(clk), .cmd(mc), .cke(cke), .n_aref(n_aref),
    .n_pre(n_pre), .n_mrs(n_mrs));
  // ****
  // bus tasks
  // ****
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // software must see the field idle before the next command
  task automatic poll();
    int n;
    n = 0;
    d = 8'hFF;
    while (d !== 8'h00 && n < 60) begin
      rd(sdrc_pkg::OFF_CMD);
      n++;
    end
  endtask
  // cycles until the next counted refresh, capped at lim
  task automatic wa(input int lim);
    int c;
    c = n_aref;
    t = 0;
    while (n_aref == c && t < lim) begin
      @(posedge clk);
      #1 t++;
      if (mc === sdrc_pkg::CMD_AREF) sa = stall;
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd(sdrc_pkg::OFF_RFCTL);
    `CHK("rfctl", 8'h10, d)
    rd(sdrc_pkg::OFF_CMD);
    `CHK("cmd", 8'h00, d)
    rd(12'h3FF);
    `CHK("unmapped", 8'h00, d)
    `CHK("cke", 1'b1, cke)
    `CHK("gate on", 1'b1, mco)
    @(posedge clk);
    en <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("gate off", 1'b0, mco)
    @(posedge clk);
    en <= 1'b1;
    $display("reset test done");
  endtask
  task automatic t_init();
    int a0, p0, m0;
    a0 = n_aref;
    p0 = n_pre;
    m0 = n_mrs;
    wr(sdrc_pkg::OFF_CMD, 8'h01);
    repeat (3) @(posedge clk);
    #1 `CHK("init stall", 1'b1, stall)
    poll();
    `CHK("init field", 8'h00, d)
    `CHK("init pre", p0 + 1, n_pre)
    `CHK("init aref", a0 + 8, n_aref)
    `CHK("init mrs", m0 + 1, n_mrs)
    `CHK("stall end", 1'b0, stall)
    $display("init test done");
  endtask
  // mode set, reserved codes and a stray exit all end with the field idle
  task automatic t_codes();
    logic [2:0] k[5] = '{3'h4, 3'h2, 3'h3, 3'h7, 3'h6};
    int m0;
    foreach (k[i]) begin
      m0 = n_mrs;
      wr(sdrc_pkg::OFF_CMD, {5'h00, k[i]});
      poll();
      `CHK("code clear", 8'h00, d)
      `CHK("code mrs", m0 + (k[i] == 3'h4), n_mrs)
    end
    $display("codes test done");
  endtask
  task automatic t_period();
    for (int s = 0; s < 8; s++) begin
      wr(sdrc_pkg::OFF_RFCTL, 8'h10 | 8'(s << 1));
      wr(sdrc_pkg::OFF_RFCTL, 8'h11 | 8'(s << 1));
      wa(400);
      wa(400);
      `CHK("interval", ivl[s], t)
    end
    `CHK("aref stall", 1'b1, sa)
    $display("period test done");
  endtask
  // deep idle, stop and a cleared enable each hold refresh off
  task automatic t_block();
    for (int k = 0; k < 3; k++) begin
      wr(sdrc_pkg::OFF_RFCTL, 8'h10);
      wr(sdrc_pkg::OFF_RFCTL, {7'h08, k != 2});
      deep <= (k == 0);
      stp <= (k == 1);
      repeat (3) @(posedge clk);
      wa(150);
      `CHK("blocked", 150, t)
    end
    deep <= 1'b0;
    stp <= 1'b0;
    $display("block test done");
  endtask
  // exit by write, by halt release, then halt release with auto exit off
  task automatic t_sref();
    for (int k = 0; k < 3; k++) begin
      wr(sdrc_pkg::OFF_RFCTL, {3'h0, k != 2, 4'h1});
      wr(sdrc_pkg::OFF_CMD, 8'h05);
      wa(100);
      rd(sdrc_pkg::OFF_CMD);
      `CHK("sref field", 8'h05, d)
      `CHK("sref cke", 1'b0, cke)
      `CHK("sref aref", 100, t)
      if (k == 0) wr(sdrc_pkg::OFF_CMD, 8'h06);
      else begin
        @(posedge clk);
        hr <= 1'b1;
        @(posedge clk);
        hr <= 1'b0;
      end
      wa(20);
      `CHK("exit aref", k != 2, t < 20)
      `CHK("exit cke", k != 2, cke)
      rd(sdrc_pkg::OFF_CMD);
      `CHK("exit field", k == 2 ? 8'h05 : 8'h00, d)
      if (k == 2) wr(sdrc_pkg::OFF_CMD, 8'h06);
    end
    $display("self refresh test done");
  endtask
  // single write on a 16-bit bus, then full page read on a 32-bit bus
  task automatic t_cpu();
    logic [26:0] a;
    int n, c, m0, p0;
    a = 27'h2B4C6DA;
    for (int b = 0; b < 2; b++) begin
      m0 = n_mrs;
      p0 = n_pre;
      n = 0;
      c = 0;
      @(posedge clk);
      aty <= {b[0], ~b[0]};
      b32 <= b[0];
      bl <= {1'b0, b[0]};
      be <= 2'h1;
      cwr <= ~b[0];
      ca <= a;
      req <= 1'b1;
      while (ack !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1 n++;
        if (mc === sdrc_pkg::CMD_ACT) c = n;
        if (mc === sdrc_pkg::CMD_ACT) `CHK("row", 16'(a >> (10 + b)), ma)
        if (mc === sdrc_pkg::CMD_MRS) `CHK("mrs word", 16'h0027, ma)
        if (mc === sdrc_pkg::CMD_RD || mc === sdrc_pkg::CMD_WR) begin
          `CHK("col", (11'(a >> (1 + b)) & 11'h3FF) | (b ? 11'h0 : 11'h400), ma[10:0])
          `CHK("mask", b ? 2'h0 : 2'h2, {hm, lm})
        end
      end
      @(posedge clk);
      req <= 1'b0;
      `CHK("ack", b ? 14 : 6, n - c)
      `CHK("burst mrs", m0 + b, n_mrs)
      `CHK("burst pre", p0 + b, n_pre)
    end
    $display("cpu test done");
  endtask
  // a reset in mid-run stops refresh
  task automatic t_rerun();
    wr(sdrc_pkg::OFF_RFCTL, 8'h01);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    wa(100);
    `CHK("rerun aref", 100, t)
    $display("rerun test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d bad %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // tests need under 10000 cycles, so 40000 means a hang
  initial begin
    #320000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_init();
    t_codes();
    t_period();
    t_block();
    t_sref();
    wr(sdrc_pkg::OFF_RFCTL, 8'h10);
    t_cpu();
    t_rerun();
    give_verdict();
  end
endmodule
`default_nettype wire
